// ### scs_pkg.sv
// Shared constants and types for the serial configuration sequencer.
// Assumes a 40 MHz system clock on both ends and a host-made link clock.
package scs_pkg;

   // ==========================================
   // Clock rate and counter width
   localparam int unsigned CLK_MHZ = 40;
   localparam int unsigned CNT_W   = 17;

   // ==========================================
   // Times as printed and derived cycle counts
   localparam int unsigned REQ_TO_LOW_NS  = 600;
   localparam int unsigned REQ_TO_LOW_CYC = REQ_TO_LOW_NS * CLK_MHZ / 1000;
   localparam int unsigned CFG_LOW_US     = 2;
   localparam int unsigned CFG_LOW_CYC    = CFG_LOW_US * CLK_MHZ;
   localparam int unsigned STATUS_MIN_US  = 268;
   localparam int unsigned STATUS_MIN_CYC = STATUS_MIN_US * CLK_MHZ;
   localparam int unsigned STATUS_MAX_US  = 1506;
   localparam int unsigned STATUS_MAX_CYC = STATUS_MAX_US * CLK_MHZ;
   localparam int unsigned ST2CK_US       = 2;
   localparam int unsigned ST2CK_CYC      = ST2CK_US * CLK_MHZ;
   localparam int unsigned CF2CK_US       = 1506;
   localparam int unsigned CF2CK_CYC      = CF2CK_US * CLK_MHZ;
   localparam int unsigned UM_MIN_US      = 175;
   localparam int unsigned UM_MIN_CYC     = UM_MIN_US * CLK_MHZ;
   localparam int unsigned UM_MAX_US      = 437;
   localparam int unsigned UM_MAX_CYC     = UM_MAX_US * CLK_MHZ;
   localparam int unsigned INIT_MIN_CLKS  = 8576;
   localparam int unsigned CONFIG_CLOCK_MAX_MHZ   = 125;
   localparam int unsigned CU_PERIODS     = 4;
   localparam int unsigned CU_NS          = CU_PERIODS * 1000 / CONFIG_CLOCK_MAX_MHZ;
   localparam int unsigned CU_CYC         = (CU_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned STROBE_NS      = 250;
   localparam int unsigned STROBE_CYC     = (STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned TAIL_FALLS     = 2;

   // ==========================================
   // Types
   typedef enum logic [1:0] {
      SCS_SRC_OSC  = 2'h0,
      SCS_SRC_USR  = 2'h1,
      SCS_SRC_CONFIG_CLOCK = 2'h2
   } scs_init_src_t;

   typedef enum logic [2:0] {
      SCS_D_POR    = 3'h0,
      SCS_D_RESET  = 3'h1,
      SCS_D_STLOW  = 3'h2,
      SCS_D_LOAD   = 3'h3,
      SCS_D_TAIL   = 3'h4,
      SCS_D_INIT   = 3'h5,
      SCS_D_USER   = 3'h6
   } scs_dev_state_t;

   typedef enum logic [2:0] {
      SCS_H_IDLE   = 3'h0,
      SCS_H_REQ    = 3'h1,
      SCS_H_WAIT   = 3'h2,
      SCS_H_SHIFT  = 3'h3,
      SCS_H_TAIL   = 3'h4,
      SCS_H_PARK   = 3'h5
   } scs_host_state_t;

endpackage : scs_pkg

// ### scs_link_if.sv
// Link between configuration host and device.
// Status line is open drain; the resolved level is formed here.
`timescale 1ns/1ps
interface scs_link_if #(
   parameter int DW = 1
);
   logic          config_req_n;
   logic          config_clock;
   logic [DW-1:0] serial_config_data;
   logic          config_complete;
   logic          dev_status_oe_n;
   logic          host_status_oe_n;
   logic          status_n;
   logic          init_done;

   // Wired-AND of the two open-drain drivers
   assign status_n = dev_status_oe_n & host_status_oe_n;

   modport device (
      input  config_req_n,
      input  config_clock,
      input  serial_config_data,
      input  status_n,
      output dev_status_oe_n,
      output config_complete,
      output init_done
   );

   modport host (
      output config_req_n,
      output config_clock,
      output serial_config_data,
      output host_status_oe_n,
      input  status_n,
      input  config_complete,
      input  init_done
   );
endinterface : scs_link_if

// ### scs_device.sv
// Device end of the serial configuration sequencer.
// Assumes the host makes config_clock and keeps its own timing.
`timescale 1ns/1ps
module scs_device #(
   parameter int                     DW          = 1,
   parameter int                     CFG_BITS    = 64,
   parameter logic [scs_pkg::CNT_W-1:0] POR_CYC  = 17'h00064,
   parameter logic [scs_pkg::CNT_W-1:0] STATUS_MIN = scs_pkg::CNT_W'(scs_pkg::STATUS_MIN_CYC),
   parameter logic [scs_pkg::CNT_W-1:0] INIT_OSC = scs_pkg::CNT_W'(scs_pkg::UM_MIN_CYC),
   parameter logic [scs_pkg::CNT_W-1:0] INIT_CLKS = scs_pkg::CNT_W'(scs_pkg::INIT_MIN_CLKS)
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   scs_link_if.device                  link,
   input  wire scs_pkg::scs_init_src_t init_src,
   input  wire logic                   init_done_en,
   input  wire logic                   dual_purpose_en,
   input  wire logic                   user_startup_clock,
   input  wire logic                   recon_strobe,
   input  wire logic                   wd_strobe,
   output logic                        user_mode_r,
   output logic                        user_io_r,
   output logic                        cfg_parity_r,
   output logic                        wd_restart_r
);
   import scs_pkg::*;

   localparam int BEATS = CFG_BITS / DW;
   localparam int BW    = $clog2(BEATS + 1);

   initial begin
      if (!(DW == 1 || DW == 4) || CFG_BITS % DW != 0 || BEATS < 2 || POR_CYC == 0)
         $error("scs_device: unsupported parameters");
   end

   // ==========================================
   // Link domain (config_clock)
   logic          link_clear_r;
   wire           link_rst = rst | link_clear_r;
   logic [BW-1:0] beat_l;
   logic          done_l;
   logic          parity_l;
   logic [1:0]    fall_l;
   logic          edges_l;
   logic [CNT_W-1:0] dinit_l;
   logic          dinit_done_l;

   wire last_beat = (beat_l == BW'(BEATS - 1));

   always_ff @(posedge link.config_clock or posedge link_rst) begin
      if (link_rst) begin
         beat_l   <= '0;
         done_l   <= 1'b0;
         parity_l <= 1'b0;
      end else if (!done_l) begin
         beat_l   <= beat_l + BW'(1);
         done_l   <= last_beat;
         parity_l <= parity_l ^ (^link.serial_config_data);
      end
   end

   always_ff @(negedge link.config_clock or posedge link_rst) begin
      if (link_rst) begin
         fall_l  <= '0;
         edges_l <= 1'b0;
      end else if (done_l && !edges_l) begin
         fall_l  <= fall_l + 2'h1;
         edges_l <= (fall_l == 2'(TAIL_FALLS - 1));
      end
   end

   always_ff @(posedge link.config_clock or posedge link_rst) begin
      if (link_rst) begin
         dinit_l      <= '0;
         dinit_done_l <= 1'b0;
      end else if (edges_l && !dinit_done_l) begin
         dinit_l      <= dinit_l + CNT_W'(1);
         dinit_done_l <= (dinit_l == INIT_CLKS - CNT_W'(1));
      end
   end

   // ==========================================
   // Synchronisers into clk domain
   localparam int SW = 9;
   logic [SW-1:0] meta_r;
   logic [SW-1:0] sync_r;
   logic          usr_d_r;

   wire [SW-1:0] async_in = {wd_strobe, recon_strobe, user_startup_clock,
                             link.serial_config_data[0], dinit_done_l, edges_l,
                             done_l, link.status_n, link.config_req_n};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_r  <= '1;
         sync_r  <= '1;
         usr_d_r <= 1'b1;
      end else begin
         meta_r  <= async_in;
         sync_r  <= meta_r;
         usr_d_r <= sync_r[6];
      end
   end

   wire req_n_s   = sync_r[0];
   wire status_s  = sync_r[1];
   wire done_s    = sync_r[2];
   wire edges_s   = sync_r[3];
   wire dinit_s   = sync_r[4];
   wire data_s    = sync_r[5];
   wire usr_rise  = sync_r[6] & ~usr_d_r;

   // ==========================================
   // Strobe width filters
   logic [1:0] strobe_fire;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_strobe
         logic [3:0] cnt_r;
         logic       fire_r;
         wire        lvl = sync_r[7 + g];
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               cnt_r  <= '0;
               fire_r <= 1'b0;
            end else begin
               cnt_r  <= !lvl ? 4'h0 : (cnt_r == 4'(STROBE_CYC) ? cnt_r : cnt_r + 4'h1);
               fire_r <= lvl && (cnt_r == 4'(STROBE_CYC - 1));
            end
         end
         assign strobe_fire[g] = fire_r;
      end
   endgenerate

   // ==========================================
   // Sequencer
   scs_dev_state_t   state_r;
   scs_dev_state_t   state_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic             usr_phase_r;

   wire cnt_hit_por  = (cnt_r == POR_CYC - CNT_W'(1));
   wire cnt_hit_st   = (cnt_r == STATUS_MIN - CNT_W'(1));
   wire cnt_hit_osc  = (cnt_r == INIT_OSC - CNT_W'(1));
   wire cnt_hit_cu   = (cnt_r == CNT_W'(CU_CYC - 1));
   wire cnt_hit_usr  = (cnt_r == INIT_CLKS - CNT_W'(1));
   wire recon        = strobe_fire[0];
   wire init_over    = (init_src == SCS_SRC_OSC)  ? cnt_hit_osc :
                       (init_src == SCS_SRC_CONFIG_CLOCK) ? dinit_s :
                       (usr_phase_r && usr_rise && cnt_hit_usr);

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         SCS_D_POR:   if (cnt_hit_por) state_nxt = req_n_s ? SCS_D_STLOW : SCS_D_RESET;
         SCS_D_RESET: if (req_n_s) state_nxt = SCS_D_STLOW;
         SCS_D_STLOW: if (cnt_hit_st) state_nxt = SCS_D_LOAD;
         SCS_D_LOAD:  if (done_s) state_nxt = SCS_D_TAIL;
         SCS_D_TAIL:  if (edges_s) state_nxt = SCS_D_INIT;
         SCS_D_INIT:  if (init_over) state_nxt = SCS_D_USER;
         SCS_D_USER:  state_nxt = SCS_D_USER;
         default:     state_nxt = SCS_D_POR;
      endcase
      if (state_r != SCS_D_POR && !req_n_s)
         state_nxt = SCS_D_RESET;
      else if (state_r != SCS_D_POR && recon)
         state_nxt = SCS_D_STLOW;
   end

   // Startup clock enabled after CU_CYC, 2 clk cycles (4 periods at 125 MHz)
   wire cnt_clear = (state_nxt != state_r) ||
                    (state_r == SCS_D_INIT && init_src == SCS_SRC_USR &&
                     !usr_phase_r && cnt_hit_cu);
   wire cnt_step  = (state_r != SCS_D_INIT) || (init_src != SCS_SRC_USR) ||
                    !usr_phase_r || usr_rise;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r     <= SCS_D_POR;
         cnt_r       <= '0;
         usr_phase_r <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         cnt_r       <= cnt_clear ? '0 : (cnt_step ? cnt_r + CNT_W'(1) : cnt_r);
         usr_phase_r <= (state_nxt != SCS_D_INIT) ? 1'b0 :
                        (usr_phase_r | (cnt_clear & (state_nxt == state_r)));
      end
   end

   // ==========================================
   // Link-facing and user outputs
   logic status_oe_n_r;
   logic complete_r;
   logic init_done_r;

   wire in_user = (state_nxt == SCS_D_USER);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status_oe_n_r <= 1'b0;
         complete_r    <= 1'b0;
         init_done_r   <= 1'b1;
         link_clear_r  <= 1'b1;
         user_mode_r   <= 1'b0;
         user_io_r     <= 1'b0;
         cfg_parity_r  <= 1'b0;
         wd_restart_r  <= 1'b0;
      end else begin
         status_oe_n_r <= !(state_nxt == SCS_D_POR || state_nxt == SCS_D_RESET ||
                            state_nxt == SCS_D_STLOW);
         complete_r    <= (state_nxt == SCS_D_TAIL || state_nxt == SCS_D_INIT || in_user);
         init_done_r   <= init_done_en ? in_user : 1'b1;
         link_clear_r  <= (state_nxt == SCS_D_POR || state_nxt == SCS_D_RESET ||
                           state_nxt == SCS_D_STLOW);
         user_mode_r   <= in_user;
         user_io_r     <= in_user && dual_purpose_en && data_s;
         if (state_r == SCS_D_LOAD && done_s)
            cfg_parity_r <= parity_l;
         wd_restart_r  <= strobe_fire[1] && in_user;
      end
   end

   // Status pin is driven low when enable is low
   assign link.dev_status_oe_n = status_oe_n_r;
   assign link.config_complete = complete_r;
   assign link.init_done       = init_done_r;

endmodule : scs_device

// ### scs_host.sv
// Host end: makes config_clock from clk and shifts the bitstream out.
// Assumes the user side offers data beats with a valid/ready handshake.
`timescale 1ns/1ps
module scs_host #(
   parameter int                     DW        = 1,
   parameter int                     CLK_HALF  = 2,
   parameter bit                     MONITOR   = 1'b1,
   parameter logic [scs_pkg::CNT_W-1:0] CF2CK  = scs_pkg::CNT_W'(scs_pkg::CF2CK_CYC),
   parameter logic [scs_pkg::CNT_W-1:0] INIT_CLKS = scs_pkg::CNT_W'(scs_pkg::INIT_MIN_CLKS)
) (
   input  wire logic          clk,
   input  wire logic          rst,
   scs_link_if.host           link,
   input  wire logic          start,
   input  wire logic          hold_status,
   input  wire logic          config_clock_init,
   input  wire logic [DW-1:0] data_in,
   input  wire logic          data_valid,
   output logic               data_ready_r,
   output logic               busy_r,
   output logic               done_r,
   output logic               user_seen_r
);
   import scs_pkg::*;

   initial begin
      if (CLK_HALF < 1 || CLK_HALF > 255 || !(DW == 1 || DW == 4))
         $error("scs_host: unsupported parameters");
   end

   // ==========================================
   // Input synchronisers
   logic [2:0] meta_r;
   logic [2:0] sync_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= {link.init_done, link.config_complete, link.status_n};
         sync_r <= meta_r;
      end
   end

   wire status_s   = sync_r[0];
   wire complete_s = sync_r[1];

   // ==========================================
   // Sequencer and clock divider
   scs_host_state_t  state_r;
   scs_host_state_t  state_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [7:0]       div_r;
   logic             config_clock_r;
   logic             have_r;
   logic [DW-1:0]    data_r;
   logic             req_n_r;

   wire tick      = (div_r == 8'(CLK_HALF - 1));
   wire accept    = data_valid & data_ready_r;
   wire rise      = tick & ~config_clock_r & have_r;
   wire fall      = tick & config_clock_r;
   wire tail_last = (cnt_r == (config_clock_init ? INIT_CLKS + CNT_W'(TAIL_FALLS) :
                               CNT_W'(TAIL_FALLS)) - CNT_W'(1));

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         SCS_H_IDLE, SCS_H_PARK: if (start) state_nxt = SCS_H_REQ;
         SCS_H_REQ:   if (cnt_r == CNT_W'(CFG_LOW_CYC - 1)) state_nxt = SCS_H_WAIT;
         SCS_H_WAIT:  if (MONITOR ? (status_s && cnt_r == CNT_W'(ST2CK_CYC - 1))
                                  : (cnt_r == CF2CK - CNT_W'(1)))
                         state_nxt = SCS_H_SHIFT;
         SCS_H_SHIFT: if (complete_s && !config_clock_r && !have_r) state_nxt = SCS_H_TAIL;
         SCS_H_TAIL:  if (fall && tail_last) state_nxt = SCS_H_PARK;
         default:     state_nxt = SCS_H_IDLE;
      endcase
   end

   wire in_clk   = (state_r == SCS_H_SHIFT) || (state_r == SCS_H_TAIL);
   wire have_nxt = (have_r & ~fall) | accept;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= SCS_H_IDLE;
         cnt_r   <= '0;
         div_r   <= '0;
         config_clock_r  <= 1'b0;
         have_r  <= 1'b0;
         data_r  <= '0;
         req_n_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         if (state_nxt != state_r)
            cnt_r <= '0;
         else if (state_r == SCS_H_WAIT && MONITOR && !status_s)
            cnt_r <= '0;
         else if (state_r != SCS_H_TAIL || fall)
            cnt_r <= cnt_r + CNT_W'(1);
         div_r   <= (!in_clk || tick) ? 8'h00 : div_r + 8'h01;
         if (state_r == SCS_H_TAIL)
            config_clock_r <= tick ? ~config_clock_r : config_clock_r;
         else
            config_clock_r <= (state_r == SCS_H_SHIFT) ? (rise | (config_clock_r & ~fall)) : 1'b0;
         have_r  <= have_nxt & (state_r == SCS_H_SHIFT);
         if (accept)
            data_r <= data_in;
         req_n_r <= (state_nxt != SCS_H_REQ);
      end
   end

   // ==========================================
   // User-side status
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         data_ready_r <= 1'b0;
         busy_r       <= 1'b0;
         done_r       <= 1'b0;
         user_seen_r  <= 1'b0;
      end else begin
         data_ready_r <= (state_nxt == SCS_H_SHIFT) && !complete_s && !have_nxt;
         busy_r       <= (state_nxt != SCS_H_IDLE) && (state_nxt != SCS_H_PARK);
         done_r       <= (state_nxt == SCS_H_PARK);
         user_seen_r  <= sync_r[2] && (state_r == SCS_H_PARK);
      end
   end

   assign link.config_clock       = config_clock_r;
   assign link.config_req_n       = req_n_r;
   assign link.serial_config_data = data_r;
   assign link.host_status_oe_n   = ~hold_status;

endmodule : scs_host

// ### scs_assertions.sv
// Checker for the host to device configuration link.
// Assumes the link signals and the system clock of both ends.
`timescale 1ns/1ps
module scs_assertions #(
   parameter int DW         = 1,
   parameter int CFG_BITS   = 64,
   parameter int STATUS_MIN = 20
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic config_req_n,
   input wire logic config_clock,
   input wire logic config_complete,
   input wire logic dev_status_oe_n,
   input wire logic status_n,
   input wire logic init_done
);
   import scs_pkg::*;
   // ============
   // Run counters
   logic       ck_d_r;
   logic [7:0] lo_r;
   logic [7:0] st_r;
   logic [7:0] cd_r;
   logic [7:0] beat_r;
   logic [1:0] fall_r;
   wire        rise = config_clock & ~ck_d_r;
   wire        fall = ~config_clock & ck_d_r;
   wire        beat = rise & status_n & ~config_complete;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ck_d_r <= 1'b0;
         lo_r   <= 8'h00;
         st_r   <= 8'h00;
         cd_r   <= 8'h00;
         beat_r <= 8'h00;
         fall_r <= 2'h0;
      end else begin
         ck_d_r <= config_clock;
         lo_r   <= dev_status_oe_n ? 8'h00 : lo_r + {7'h00, ~&lo_r};
         st_r   <= !status_n ? 8'h00 : st_r + {7'h00, ~&st_r};
         cd_r   <= !config_complete ? 8'h00 : cd_r + {7'h00, ~&cd_r};
         beat_r <= !config_req_n ? 8'h00 : beat_r + {7'h00, beat};
         fall_r <= !config_complete ? 2'h0 : fall_r + {1'b0, fall & ~&fall_r};
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // ============
   // Link checks
   AST_REQ_CD: assert property ($fell(config_req_n) |-> ##[1:24] !config_complete)
      else $error("completion not low after request");
   AST_REQ_ST: assert property ($fell(config_req_n) |-> ##[1:24] !dev_status_oe_n)
      else $error("status not pulled after request");
   AST_ST_MIN: assert property ($rose(dev_status_oe_n) |-> lo_r >= STATUS_MIN)
      else $error("status pulse too short");
   AST_CD_ST: assert property ($rose(config_complete) |-> dev_status_oe_n && status_n)
      else $error("completion rose while status low");
   AST_BEATS: assert property ($rose(config_complete) |-> beat_r == CFG_BITS / DW)
      else $error("completion on wrong beat count");
   AST_TAIL: assert property ($rose(init_done) |-> fall_r >= 2'h2 && config_complete)
      else $error("init done without two tail falls");
   AST_PARK: assert property (cd_r == 8'hFF |-> init_done && !config_clock)
      else $error("link clock not parked after load");
   AST_FIRST: assert property ($rose(config_clock) |-> st_r >= ST2CK_CYC)
      else $error("clock edge too soon after status");

   cover property ($fell(config_req_n));
   cover property ($rose(config_complete));
   cover property ($rose(init_done));
endmodule : scs_assertions

// ### tb_serial_config_sequencer.sv
// Testbench joining host and device ends over the link interface.
// Assumes the package, interface, both ends and the checker compiled first.
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin error_cnt++; \
   $display("Error %s expected %0h seen %0h", n, e, s); end end
module tb_serial_config_sequencer;
   import scs_pkg::*;
   localparam int          NB  = 64;
   localparam logic [63:0] PAT = 64'hA5C3_0F1E_9B27_D468;
   logic          clk = 1'b0;
   logic          rst = 1'b1;
   logic          user_startup_clock = 1'b0;
   logic          start = 1'b0;
   logic          hold_status = 1'b0;
   logic          config_clock_init = 1'b0;
   logic [0:0]    data_in = 1'b0;
   logic          data_valid = 1'b0;
   logic          init_done_en = 1'b1;
   logic          dual_purpose_en = 1'b0;
   logic          recon_strobe = 1'b0;
   logic          wd_strobe = 1'b0;
   scs_init_src_t init_src = SCS_SRC_OSC;
   logic          user_mode_r, user_io_r, cfg_parity_r, wd_restart_r;
   logic          data_ready_r, busy_r, done_r, user_seen_r;
   int            error_cnt = 0;
   int            cmp_count = 0;

   always #12.5 clk = ~clk;
   always #40 user_startup_clock = ~user_startup_clock;

   scs_link_if scs_link_if_inst ();
   scs_device #(.STATUS_MIN(17'h00014), .INIT_OSC(17'h0001E),
      .INIT_CLKS(17'h00008)) scs_device_inst (.clk(clk), .rst(rst),
      .link(scs_link_if_inst), .init_src(init_src), .init_done_en(init_done_en),
      .dual_purpose_en(dual_purpose_en), .user_startup_clock(user_startup_clock),
      .recon_strobe(recon_strobe), .wd_strobe(wd_strobe), .user_mode_r(user_mode_r),
      .user_io_r(user_io_r), .cfg_parity_r(cfg_parity_r), .wd_restart_r(wd_restart_r));
   scs_host #(.CF2CK(17'h00032), .INIT_CLKS(17'h00008)) scs_host_inst (.clk(clk),
      .rst(rst), .link(scs_link_if_inst), .start(start), .hold_status(hold_status),
      .config_clock_init(config_clock_init), .data_in(data_in), .data_valid(data_valid),
      .data_ready_r(data_ready_r), .busy_r(busy_r), .done_r(done_r),
      .user_seen_r(user_seen_r));
   scs_assertions scs_assertions_inst (
      .clk(clk), .rst(rst), .config_req_n(scs_link_if_inst.config_req_n),
      .config_clock(scs_link_if_inst.config_clock),
      .config_complete(scs_link_if_inst.config_complete),
      .dev_status_oe_n(scs_link_if_inst.dev_status_oe_n),
      .status_n(scs_link_if_inst.status_n), .init_done(scs_link_if_inst.init_done));

   task automatic conclude;
      if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude

   task automatic fail(input string w);
      error_cnt++;
      $display("Error %s expected done seen timeout", w);
      conclude();
   endtask : fail

   task automatic wt(ref logic s, input logic v, input int n, output int c);
      c = 0;
      while (s !== v) begin
         @(posedge clk);
         c++;
         if (c > n) fail("wait");
      end
   endtask : wt

   task automatic por;
      int c;
      `CHK("por_status", 1'b0, scs_link_if_inst.status_n)
      `CHK("por_done", 1'b0, scs_link_if_inst.config_complete)
      wt(scs_link_if_inst.status_n, 1'b1, 200, c);
      `CHK("por_len", 1'b1, c >= 110)
   endtask : por

   // One full load; h holds status low to postpone it
   task automatic load(input scs_init_src_t s, input logic en, dc, h, input int mn);
      int c, n, k;
      init_src <= s;
      init_done_en <= en;
      config_clock_init <= dc;
      hold_status <= h;
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      wt(scs_link_if_inst.status_n, 1'b0, 30, c);
      if (!h) `CHK("cd_low", 1'b0, scs_link_if_inst.config_complete)
      if (h) begin
         repeat (300) @(posedge clk);
         `CHK("held_cd_low", 1'b0, scs_link_if_inst.config_complete)
         `CHK("held_status", 1'b0, scs_link_if_inst.status_n)
         `CHK("held_busy", 1'b1, busy_r)
         hold_status <= 1'b0;
      end
      wt(scs_link_if_inst.status_n, 1'b1, 400, c);
      if (!h) `CHK("st_pulse", 1'b1, c >= 95 && c <= 110)
      n = 0;
      k = 0;
      data_in <= PAT[0];
      data_valid <= 1'b1;
      while (n < NB) begin
         @(posedge clk);
         k++;
         if (data_ready_r === 1'b1) begin
            n++;
            data_in <= PAT[n % NB];
         end
         if (n == NB) data_valid <= 1'b0;
         if (k > 2000) fail("feed");
      end
      wt(scs_link_if_inst.config_complete, 1'b1, 40, c);
      `CHK("init_low", ~en, scs_link_if_inst.init_done)
      wt(user_mode_r, 1'b1, 600, c);
      `CHK("init_min", 1'b1, c >= mn)
      if (s == SCS_SRC_OSC) `CHK("init_max", 1'b1, c <= 30 * UM_MAX_US / UM_MIN_US)
      `CHK("init_done", 1'b1, scs_link_if_inst.init_done)
      `CHK("parity", ^PAT, cfg_parity_r)
      `CHK("status_um", 1'b1, scs_link_if_inst.status_n)
      `CHK("user_io", dual_purpose_en & PAT[NB-1], user_io_r)
      wt(done_r, 1'b1, 200, c);
   endtask : load

   // Short strobe ignored, long strobe restarts once
   task automatic wd;
      int seen;
      for (int t = 0; t < 2; t++) begin
         seen = 0;
         wd_strobe <= 1'b1;
         for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            if (wd_restart_r === 1'b1) seen++;
            if (i == 7 + 6 * t) wd_strobe <= 1'b0;
         end
         `CHK("wd_pulse", t, seen)
      end
   endtask : wd

   task automatic recon;
      int c;
      recon_strobe <= 1'b1;
      wt(scs_link_if_inst.status_n, 1'b0, 30, c);
      recon_strobe <= 1'b0;
      `CHK("recon_len", 1'b1, c >= 10)
      wt(scs_link_if_inst.status_n, 1'b1, 100, c);
   endtask : recon

   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      por();
      load(SCS_SRC_OSC, 1'b1, 1'b0, 1'b0, 30);
      load(SCS_SRC_USR, 1'b0, 1'b0, 1'b0, 22);
      load(SCS_SRC_CONFIG_CLOCK, 1'b1, 1'b1, 1'b0, 28);
      load(SCS_SRC_OSC, 1'b1, 1'b0, 1'b1, 30);
      wd();
      recon();
      dual_purpose_en <= 1'b1;
      load(SCS_SRC_OSC, 1'b1, 1'b0, 1'b0, 30);
      conclude();
   end
endmodule : tb_serial_config_sequencer
